// ===== haptic_pwm_effect_driver_tb_top.sv
`timescale 1ns/100ps
module haptic_pwm_effect_driver_tb_top
  import hped_pkg::*;
  ;
  localparam int TP = 2000;
  localparam int LIMIT = 60000;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [1:0] r;} hped_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic pwm_out, amp_shutdown_n, effect_busy, drive;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int unsigned driven;
  int fail_count = 0, total_checks = 0, cyc = 0;
  hped_row_t rows [8] = '{'{CTRL_OFF, 32'h0, RESP_OKAY}, '{STATUS_OFF, 32'h0, RESP_OKAY},
    '{PLAY_OFF, 32'h0, RESP_OKAY}, '{UPDATE_OFF, 32'h0, RESP_OKAY}, '{CARDIV_OFF, 32'h21, RESP_OKAY},
    '{TICKDIV_OFF, 32'h72, RESP_OKAY}, '{12'h020, 32'h0, RESP_SLVERR}, '{12'h006, 32'h0, RESP_SLVERR}};

  // Effect 3 left out of the build; short tick keeps the run small
  hped_driver #(.EFFECT_ENABLE(16'h3FF7), .TICK_PERIOD(TP)) hped_driver_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pwm_out, .amp_shutdown_n, .effect_busy);
  hped_actuator_model hped_actuator_model_i (.aclk, .amp_shutdown_n, .pwm_out, .drive, .driven);
  ////////////////////////////////////////////////////////////
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  // Cycle count doubles as the hang limit
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      close_out();
    end
  end
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word
  task automatic chk_bit(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // Handshakes are sampled mid-cycle and released at the next rising edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end while (tb !== 1'b1);
    chk_word("bresp", 32'(er), 32'(r));
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ta, tr;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end while (tr !== 1'b1);
    chk_word("rresp", 32'(er), 32'(r));
  endtask : rd
  task automatic pwm_high(output int h);
    h = 0;
    repeat (255) begin
      @(negedge aclk);
      h += int'(pwm_out === 1'b1);
    end
  endtask : pwm_high
  // Within about 300 cycles of the expected end
  task automatic end_near(input int t0, input int want);
    while (effect_busy !== 1'b0) @(negedge aclk);
    chk_bit("end time", 1'b1, (cyc - t0 > want - 300) && (cyc - t0 < want + 300));
  endtask : end_near
  ////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    int h;
    int t0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk_bit("pwm_out", 1'b0, pwm_out);
    chk_bit("amp_shutdown_n", 1'b0, amp_shutdown_n);
    $display("reset test done");
    // Divider reset values set the carrier and tick rates
    foreach (rows[i]) begin
      rd(rows[i].a, rows[i].r, d);
      chk_word("rdata", rows[i].d, d);
    end
    wr(12'h020, 32'h1, RESP_SLVERR);
    $display("register table test done");
    // Effect 1 has two steps, the second last; effect 2 one last step
    wr(CARDIV_OFF, 32'h0, RESP_OKAY);
    wr(SEQADDR_OFF, 32'h10, RESP_OKAY);
    wr(SEQDATA_OFF, 32'h080, RESP_OKAY);
    wr(SEQDATA_OFF, 32'h140, RESP_OKAY);
    wr(SEQADDR_OFF, 32'h20, RESP_OKAY);
    wr(SEQDATA_OFF, 32'h1C0, RESP_OKAY);
    wr(SEQADDR_OFF, 32'h11, RESP_OKAY);
    rd(SEQDATA_OFF, RESP_OKAY, d);
    chk_word("seq entry", 32'h140, d);
    // Every index: disabled and out-of-range ones are refused
    for (int e = 0; e < 16; e++) begin
      wr(PLAY_OFF, 32'(e), RESP_OKAY);
      rd(STATUS_OFF, RESP_OKAY, d);
      chk_bit("busy", e != 3 && e < 14, d[0]);
      chk_bit("reject", e == 3 || e > 13, d[1]);
      wr(STATUS_OFF, 32'h2, RESP_OKAY);
      wr(CTRL_OFF, 32'h4, RESP_OKAY);
    end
    $display("effect select test done");
    // Timer mode: duty refresh at the tick, end after the last step
    wr(PLAY_OFF, 32'h1, RESP_OKAY);
    t0 = cyc;
    rd(STATUS_OFF, RESP_OKAY, d);
    chk_word("status", 32'h8000_0101, d & 32'hFF00_0F03);
    repeat (300) @(negedge aclk);
    pwm_high(h);
    chk_word("duty first", 32'd128, 32'(h));
    while (cyc < t0 + TP + 300) @(negedge aclk);
    pwm_high(h);
    chk_word("duty second", 32'd64, 32'(h));
    end_near(t0, 2 * TP);
    h = driven;
    repeat (500) @(negedge aclk);
    chk_word("idle drive", 32'(h), 32'(driven));
    $display("timer mode test done");
    // Carrier-count mode at the smallest divider
    wr(TICKDIV_OFF, 32'd109, RESP_OKAY);
    wr(CTRL_OFF, 32'h1, RESP_OKAY);
    wr(PLAY_OFF, 32'h2, RESP_OKAY);
    end_near(cyc, 110 * 255);
    $display("carrier count test done");
    // Direct mode: nothing advances without an update write
    wr(CTRL_OFF, 32'h2, RESP_OKAY);
    wr(PLAY_OFF, 32'h1, RESP_OKAY);
    repeat (3 * TP) @(negedge aclk);
    chk_bit("busy direct", 1'b1, effect_busy);
    wr(UPDATE_OFF, 32'h0, RESP_OKAY);
    chk_bit("busy step", 1'b1, effect_busy);
    wr(UPDATE_OFF, 32'h0, RESP_OKAY);
    @(negedge aclk);
    chk_bit("busy end", 1'b0, effect_busy);
    $display("direct mode test done");
    // Stop in mid-effect under mode 3
    wr(CTRL_OFF, 32'h3, RESP_OKAY);
    wr(PLAY_OFF, 32'h1, RESP_OKAY);
    repeat (100) @(negedge aclk);
    wr(CTRL_OFF, 32'h4, RESP_OKAY);
    @(negedge aclk);
    chk_bit("busy stop", 1'b0, effect_busy);
    chk_bit("amp stop", 1'b0, amp_shutdown_n);
    chk_bit("pwm stop", 1'b0, pwm_out);
    $display("stop test done");
    // Reset in mid-effect must quiet the actuator and restore the carrier divider
    wr(PLAY_OFF, 32'h1, RESP_OKAY);
    repeat (50) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk_bit("busy reset", 1'b0, effect_busy);
    chk_bit("amp reset", 1'b0, amp_shutdown_n);
    chk_bit("pwm reset", 1'b0, pwm_out);
    rd(CARDIV_OFF, RESP_OKAY, d);
    chk_word("cardiv reset", 32'(CARDIV_RST), d);
    $display("mid-run reset test done");
    close_out();
  end
endmodule : haptic_pwm_effect_driver_tb_top

// ===== hped_actuator_model.sv
`timescale 1ns/100ps
module hped_actuator_model (
  input wire logic aclk,
  input wire logic amp_shutdown_n,
  input wire logic pwm_out,
  output logic drive,
  output int unsigned driven
);
  // A shut-down amplifier passes nothing to the motor
  assign drive = amp_shutdown_n & pwm_out;
  // Driven cycles stand in for motor energy; idle must add none
  // One process owns the count so the output has a single driver
  int unsigned count_q = 0;
  assign driven = count_q;
  always @(posedge aclk) begin
    if (drive === 1'b1) count_q <= count_q + 1;
  end
endmodule : hped_actuator_model

// ===== hped_driver.sv
`timescale 1ns/100ps
// Summary of operation
// - Amplifier input gets PWM whose duty is refreshed periodically during an effect.
// - Up to 14 effects, each a stored sequence of duty values per tick.
// - Timer mode makes carrier and 5 ms tick fully in hardware.
// - Carrier-count mode makes carrier in hardware, tick by counting carrier periods.
// - A 16-bit counter for carrier prescale; the tick uses a TICK_PERIOD-sized timer or an 8-bit period count.
// - Default carrier repeats at roughly 23 kHz.
// - Duty reload costs far under 90 cycles and never blocks other events.
// - Carrier and tick run only while playing and stop fully afterwards.
// - Starting an effect never stalls the bus; playback runs in background.
// - Separate active-low amplifier shutdown output.
// - Effects disabled at build time cannot be played.
module hped_driver
  import hped_pkg::*;
#(
  parameter int unsigned NUM_EFFECTS = 14,
  parameter int unsigned SEQ_STEPS = 16,
  parameter logic [15:0] EFFECT_ENABLE = 16'h3FFF,
  parameter int unsigned TICK_PERIOD = TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pwm_out,
  output logic amp_shutdown_n,
  output logic effect_busy
);

  localparam int unsigned MEM_N = NUM_EFFECTS * SEQ_STEPS;
  localparam int unsigned TW = $clog2(TICK_PERIOD);

  // Effect and step fields are four bits each in the sequence address
  if (NUM_EFFECTS < 1 || NUM_EFFECTS > 14 || SEQ_STEPS < 2 || SEQ_STEPS > 16 || TICK_PERIOD < 2) begin : g_chk
    $error("hped_driver: unsupported parameter values");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i+:8] = nw[8*i+:8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic effect_ok(input logic [3:0] eff);
    return (32'(eff) < NUM_EFFECTS) && EFFECT_ENABLE[eff];
  endfunction : effect_ok

  function automatic logic [7:0] mem_idx(input logic [3:0] eff, input logic [3:0] step);
    return 8'(32'(eff) * SEQ_STEPS + 32'(step));
  endfunction : mem_idx

  function automatic logic mapped(input logic [11:0] a);
    return (a[11:5] == 7'h00) && (a[1:0] == 2'h0);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] mode_q, mode_d;
  logic [15:0] cardiv_q, cardiv_d;
  logic [7:0] tickdiv_q, tickdiv_d;
  logic [7:0] seqaddr_q, seqaddr_d;
  logic [8:0] mem_q [MEM_N];
  logic [8:0] mem_d [MEM_N];
  hped_state_t state_q, state_d;
  logic reject_q, reject_d;
  logic [3:0] effect_q, effect_d;
  logic [3:0] step_q, step_d;
  logic last_q, last_d;
  logic [7:0] duty_q, duty_d;
  logic [7:0] duty_next_q, duty_next_d;
  logic [15:0] psc_q, psc_d;
  logic [7:0] carr_q, carr_d;
  logic [7:0] tdiv_cnt_q, tdiv_cnt_d;
  logic [TW-1:0] tmr_q, tmr_d;
  logic pwm_q, pwm_d, amp_q, amp_d;

  logic do_wr, car_en, period_end, tick;
  logic [31:0] wval;
  logic [8:0] entry;

  // Handshakes stay combinational; payloads come from flops
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign pwm_out = pwm_q;
  assign amp_shutdown_n = amp_q;
  assign effect_busy = (state_q == HPED_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus slave, sequence store, playback, carrier

  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    mode_d = mode_q;
    cardiv_d = cardiv_q;
    tickdiv_d = tickdiv_q;
    seqaddr_d = seqaddr_q;
    mem_d = mem_q;
    state_d = state_q;
    reject_d = reject_q;
    effect_d = effect_q;
    step_d = step_q;
    last_d = last_q;
    duty_d = duty_q;
    duty_next_d = duty_next_q;
    psc_d = psc_q;
    carr_d = carr_q;
    tdiv_cnt_d = tdiv_cnt_q;
    tmr_d = tmr_q;
    tick = 1'b0;
    entry = 9'h000;
    wval = merge(32'h0000_0000, wdata_q, wstrb_q);

    // Address and data are parked until both are here, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    do_wr = aw_hold_q && w_hold_q && !bvalid_q;

    // Carrier prescale: one enable pulse per carrier step
    car_en = (state_q == HPED_RUN) && (psc_q == cardiv_q);
    period_end = car_en && (carr_q == CARRIER_LAST);
    if (state_q == HPED_RUN) begin
      psc_d = car_en ? 16'h0000 : psc_q + 16'h0001;
      if (car_en) begin
        carr_d = period_end ? 8'h00 : carr_q + 8'h01;
      end
      // Tick source follows the selected mode
      unique case (hped_mode_t'(mode_q))
        HPED_TICK_TIMER: begin
          tick = (tmr_q == TW'(TICK_PERIOD - 1));
          tmr_d = tick ? '0 : tmr_q + TW'(1);
        end
        HPED_TICK_CARRIER: begin
          if (period_end) begin
            tick = (tdiv_cnt_q == tickdiv_q);
            tdiv_cnt_d = tick ? 8'h00 : tdiv_cnt_q + 8'h01;
          end
        end
        default: begin
          tick = do_wr && (awaddr_q == UPDATE_OFF);
        end
      endcase
      // New duty lands at a period boundary so no pulse is cut short
      if (period_end) begin
        duty_d = duty_next_q;
      end
    end

    // Each tick fetches the next stored duty, or ends after the last one
    if (tick) begin
      if (last_q) begin
        state_d = HPED_IDLE;
      end else begin
        entry = mem_q[mem_idx(effect_q, step_q)];
        duty_next_d = entry[7:0];
        last_d = entry[SEQ_LAST_BIT] || (32'(step_q) == SEQ_STEPS - 1);
        step_d = step_q + 4'h1;
      end
    end

    // Register writes; the response never waits on playback
    if (do_wr) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      unique case (awaddr_q)
        CTRL_OFF: begin
          mode_d = 2'(merge(32'(mode_q), wdata_q, wstrb_q) >> CTRL_MODE_LSB);
          if (wval[CTRL_STOP_BIT]) begin
            state_d = HPED_IDLE;
          end
        end
        STATUS_OFF: begin
          if (wval[ST_REJECT_BIT]) begin
            reject_d = 1'b0;
          end
        end
        PLAY_OFF: begin
          if (effect_ok(wval[3:0])) begin
            entry = mem_q[mem_idx(wval[3:0], 4'h0)];
            state_d = HPED_RUN;
            effect_d = wval[3:0];
            step_d = 4'h1;
            duty_next_d = entry[7:0];
            duty_d = entry[7:0];
            last_d = entry[SEQ_LAST_BIT];
            psc_d = 16'h0000;
            carr_d = 8'h00;
            tdiv_cnt_d = 8'h00;
            tmr_d = '0;
          end else begin
            reject_d = 1'b1;
          end
        end
        CARDIV_OFF: cardiv_d = 16'(merge(32'(cardiv_q), wdata_q, wstrb_q));
        TICKDIV_OFF: tickdiv_d = 8'(merge(32'(tickdiv_q), wdata_q, wstrb_q));
        SEQADDR_OFF: seqaddr_d = 8'(merge(32'(seqaddr_q), wdata_q, wstrb_q));
        SEQDATA_OFF: begin
          // Storing auto-advances so a sequence loads with repeated writes
          if (32'(seqaddr_q[7:4]) < NUM_EFFECTS && 32'(seqaddr_q[3:0]) < SEQ_STEPS) begin
            mem_d[mem_idx(seqaddr_q[7:4], seqaddr_q[3:0])] = wdata_q[8:0];
          end
          seqaddr_d = seqaddr_q + 8'h01;
        end
        default: ;
      endcase
    end

    // Reads: one outstanding, answered the cycle after arrival
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_d = 32'h0000_0000;
      unique case (s_axi_araddr)
        CTRL_OFF: rdata_d = 32'(mode_q) << CTRL_MODE_LSB;
        STATUS_OFF: begin
          rdata_d[ST_BUSY_BIT] = (state_q == HPED_RUN);
          rdata_d[ST_REJECT_BIT] = reject_q;
          rdata_d[ST_EFFECT_LSB+:4] = effect_q;
          rdata_d[ST_STEP_LSB+:4] = step_q;
          rdata_d[ST_DUTY_LSB+:8] = duty_q;
        end
        CARDIV_OFF: rdata_d = 32'(cardiv_q);
        TICKDIV_OFF: rdata_d = 32'(tickdiv_q);
        SEQADDR_OFF: rdata_d = 32'(seqaddr_q);
        SEQDATA_OFF: begin
          if (32'(seqaddr_q[7:4]) < NUM_EFFECTS && 32'(seqaddr_q[3:0]) < SEQ_STEPS) begin
            rdata_d = 32'(mem_q[mem_idx(seqaddr_q[7:4], seqaddr_q[3:0])]);
          end
        end
        default: ;
      endcase
    end

    // Idle holds the actuator still: output low, amplifier shut down
    pwm_d = (state_d == HPED_RUN) && (carr_d < duty_d);
    amp_d = (state_d == HPED_RUN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      mode_q <= CTRL_MODE_RST;
      cardiv_q <= CARDIV_RST;
      tickdiv_q <= TICKDIV_RST;
      seqaddr_q <= 8'h00;
      for (int i = 0; i < MEM_N; i++) begin
        mem_q[i] <= 9'h000;
      end
      state_q <= HPED_IDLE;
      reject_q <= 1'b0;
      effect_q <= 4'h0;
      step_q <= 4'h0;
      last_q <= 1'b0;
      duty_q <= 8'h00;
      duty_next_q <= 8'h00;
      psc_q <= 16'h0000;
      carr_q <= 8'h00;
      tdiv_cnt_q <= 8'h00;
      tmr_q <= '0;
      pwm_q <= 1'b0;
      amp_q <= 1'b0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      mode_q <= mode_d;
      cardiv_q <= cardiv_d;
      tickdiv_q <= tickdiv_d;
      seqaddr_q <= seqaddr_d;
      mem_q <= mem_d;
      state_q <= state_d;
      reject_q <= reject_d;
      effect_q <= effect_d;
      step_q <= step_d;
      last_q <= last_d;
      duty_q <= duty_d;
      duty_next_q <= duty_next_d;
      psc_q <= psc_d;
      carr_q <= carr_d;
      tdiv_cnt_q <= tdiv_cnt_d;
      tmr_q <= tmr_d;
      pwm_q <= pwm_d;
      amp_q <= amp_d;
    end
  end

endmodule : hped_driver

// ===== hped_driver_monitor.sv
`timescale 1ns/100ps
module hped_driver_monitor
  import hped_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pwm_out,
  input wire logic amp_shutdown_n,
  input wire logic effect_busy
);
  ////////////////////////////////////////////////////////////
  // One domain, so clock and reset are named once
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Address and data taken at the same edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  chk_write_answer: assert property (wr_taken |=> wr_answer)
    else $error("write response not two cycles after handshake");
  chk_write_unmapped: assert property (wr_taken ##0 (s_axi_awaddr >= 12'h020) |-> ##2 s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 12'h020
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted with response pending");
  chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted with data pending");
  // Idle for two cycles means the actuator must be fully quiet
  chk_idle_quiet: assert property (!effect_busy && !$past(effect_busy) |-> !pwm_out && !amp_shutdown_n)
    else $error("drive active while idle");
  chk_amp_on_play: assert property (effect_busy && $past(effect_busy) |-> amp_shutdown_n)
    else $error("amplifier off during effect");
  chk_pwm_gated: assert property (pwm_out |-> amp_shutdown_n)
    else $error("carrier high with amplifier off");
  cover property (effect_busy ##1 !effect_busy);
endmodule : hped_driver_monitor

bind hped_driver hped_driver_monitor hped_driver_monitor_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_out,
  .amp_shutdown_n, .effect_busy);

// ===== hped_pkg.sv
package hped_pkg;

  // Timing base
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CARRIER_STEPS = 255;
  localparam int unsigned CARRIER_HZ = 23_000;
  localparam int unsigned TICK_MS = 5;
  localparam int unsigned TICK_HZ = 1000 / TICK_MS;
  // Prescale rounds down so the carrier never drops below its target
  localparam int unsigned PRESCALE_CYCLES = CLK_HZ / (CARRIER_STEPS * CARRIER_HZ);
  localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int unsigned TICK_DIV_RST = CLK_HZ / (PRESCALE_CYCLES * TICK_HZ * CARRIER_STEPS) - 1;
  localparam logic [7:0] CARRIER_LAST = 8'(CARRIER_STEPS - 1);

  // Register byte offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] PLAY_OFF = 12'h008;
  localparam logic [11:0] UPDATE_OFF = 12'h00C;
  localparam logic [11:0] CARDIV_OFF = 12'h010;
  localparam logic [11:0] TICKDIV_OFF = 12'h014;
  localparam logic [11:0] SEQADDR_OFF = 12'h018;
  localparam logic [11:0] SEQDATA_OFF = 12'h01C;

  // Field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_STOP_BIT = 2;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_REJECT_BIT = 1;
  localparam int unsigned ST_EFFECT_LSB = 8;
  localparam int unsigned ST_STEP_LSB = 16;
  localparam int unsigned ST_DUTY_LSB = 24;
  localparam int unsigned SEQ_LAST_BIT = 8;

  // Reset values
  localparam logic [1:0] CTRL_MODE_RST = 2'h0;
  localparam logic [15:0] CARDIV_RST = 16'(PRESCALE_CYCLES - 1);
  localparam logic [7:0] TICKDIV_RST = 8'(TICK_DIV_RST);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    HPED_TICK_TIMER,
    HPED_TICK_CARRIER,
    HPED_TICK_DIRECT
  } hped_mode_t;

  typedef enum logic {
    HPED_IDLE,
    HPED_RUN
  } hped_state_t;

endpackage : hped_pkg
